/* File: rtl/ssl_pkg.sv */
// Shared constants and state types for the link sync and lock block.
// Assumes one serial bit per clock on both the transmit and receive side.
package ssl_pkg;

  localparam int FRAME_BITS = 12;
  localparam int DATA_BITS = 10;
  localparam logic [3:0] FRAME_LEN = 4'hC;
  localparam logic [3:0] LAST_BIT = 4'hB;
  localparam logic [3:0] HALF_BIT = 4'h6;
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  localparam logic [11:0] SYNC_FRAME = 12'hFC0;
  // Word clock periods a sync request must already have been held.
  localparam logic [3:0] SYNC_REQ_MIN = 4'h6;
  localparam logic [10:0] SYNC_FRAMES = 11'h402;
  localparam logic [2:0] BND_FRAMES = 3'h4;
  localparam logic [1:0] RMT_FRAMES = 2'h2;
  localparam logic [7:0] TX_PLL_CYC = 8'h20;
  localparam logic [7:0] RX_PLL_CYC = 8'h20;

  typedef enum logic [2:0] {
    TX_PLL = 3'b001,
    TX_DATA = 3'b010,
    TX_SYNC = 3'b100
  } ssl_tx_st_t;

  typedef enum logic [2:0] {
    RX_INIT = 3'b001,
    RX_HUNT = 3'b010,
    RX_LOCK = 3'b100
  } ssl_rx_st_t;

endpackage : ssl_pkg

/* File: rtl/ssl_tx_if.sv */
// Connection between the top and the serializer framing module.
// Assumes all signals belong to the clk_i domain.
`timescale 1ns/10ps
`default_nettype none
interface ssl_tx_if;
  logic [9:0] word;
  logic edge_sel;
  logic sync_req;
  logic txd;
  logic txd_oe_n;
  modport ctl (output word, edge_sel, sync_req, input txd, txd_oe_n);
  modport ser (input word, edge_sel, sync_req, output txd, txd_oe_n);
endinterface : ssl_tx_if
`default_nettype wire

/* File: rtl/ssl_tx.sv */
// Serializer framing: PLL wait, data frames and sync frame bursts.
// Assumes clk_i is the bit clock; the word clock is clk_i divided by 12.
`timescale 1ns/10ps
`default_nettype none
module ssl_tx
  import ssl_pkg::*;
(
  input wire logic clk_i, // Serial bit clock.
  input wire logic rst_i, // Synchronous reset, active high.
  ssl_tx_if.ser tx // Word in, serial bit out.
);

  ssl_tx_st_t st_r, st_nxt;
  logic [3:0] bit_r;
  logic [7:0] pll_r;
  logic [3:0] req_r;
  logic [10:0] left_r;
  logic [11:0] sh_r;
  logic [9:0] hold_r;
  logic txd_r;
  logic oe_n_r;

  wire frame_end = bit_r == LAST_BIT;
  wire latch_pt = tx.edge_sel ? (bit_r == 4'h0) : (bit_r == HALF_BIT);
  wire req_long = frame_end && tx.sync_req && req_r == SYNC_REQ_MIN;
  wire load_sync = frame_end && st_nxt == TX_SYNC;
  wire [11:0] data_frame = {START_BIT, hold_r, STOP_BIT};

  assign tx.txd = txd_r;
  assign tx.txd_oe_n = oe_n_r;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      TX_PLL: if (pll_r == TX_PLL_CYC) st_nxt = TX_DATA;
      TX_DATA: if (req_long) st_nxt = TX_SYNC;
      TX_SYNC: if (frame_end && left_r == 11'h000) st_nxt = TX_DATA;
      default: st_nxt = TX_PLL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= TX_PLL;
      bit_r <= 4'h0;
      pll_r <= 8'h00;
      req_r <= 4'h0;
      left_r <= 11'h000;
      sh_r <= 12'h000;
      hold_r <= 10'h000;
      txd_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      bit_r <= frame_end ? 4'h0 : bit_r + 4'h1;
      if (pll_r != TX_PLL_CYC)
        pll_r <= pll_r + 8'h01;
      if (st_r != TX_DATA || !tx.sync_req || st_nxt == TX_SYNC)
        req_r <= 4'h0;
      else if (frame_end && req_r != SYNC_REQ_MIN)
        req_r <= req_r + 4'h1;
      if (load_sync)
        left_r <= (st_r == TX_SYNC) ? left_r - 11'h001 : SYNC_FRAMES - 11'h001;
      if (latch_pt && st_r != TX_SYNC)
        hold_r <= tx.word;
      if (frame_end)
        sh_r <= load_sync ? SYNC_FRAME : data_frame;
      else
        sh_r <= {sh_r[10:0], STOP_BIT};
      txd_r <= sh_r[11];
      oe_n_r <= st_nxt == TX_PLL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [10:0] sf_cnt_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (load_sync && st_r != TX_SYNC))
      sf_cnt_r <= 11'h001;
    else if (load_sync)
      sf_cnt_r <= sf_cnt_r + 11'h001;
  end

  a_sync_burst_len: assert property (
    st_r == TX_SYNC && st_nxt == TX_DATA |-> sf_cnt_r == SYNC_FRAMES)
    else $error("sync burst length is not 1026 frames");
  a_sync_frame_shape: assert property (
    load_sync |-> ##2 tx.txd [*6] ##1 !tx.txd [*6])
    else $error("sync frame is not six ones then six zeros");
  a_data_frame_bits: assert property (
    frame_end && st_nxt == TX_DATA |-> ##2 tx.txd ##11 !tx.txd)
    else $error("data frame start or stop bit wrong");
  a_frame_period: assert property (
    frame_end |=> !frame_end [*8] ##1 !frame_end [*3] ##1 frame_end)
    else $error("frame is not twelve bits long");
  a_sync_cause: assert property (
    st_r == TX_DATA && !tx.sync_req |=> st_r != TX_SYNC)
    else $error("sync burst started without a request");
  a_hold_in_sync: assert property (
    st_r == TX_SYNC |=> $stable(hold_r))
    else $error("input word latched during sync burst");
  a_pll_hiz: assert property (
    st_r == TX_PLL && pll_r != TX_PLL_CYC |=> tx.txd_oe_n)
    else $error("serial output driven before PLL wait ended");

  c_sync_start: cover property (st_r == TX_DATA ##1 st_r == TX_SYNC);
  c_sync_end: cover property (st_r == TX_SYNC ##1 st_r == TX_DATA);

endmodule : ssl_tx
`default_nettype wire

/* File: rtl/ssl_top.sv */
// Link sync and lock: serializer framing and deserializer lock tracking.
// Assumes clk_i is the transmit bit clock and that the reference clock
// samples the serial input once per bit, free running.
`timescale 1ns/10ps
`default_nettype none
module ssl_top
  import ssl_pkg::*;
(
  input wire logic clk_i, // Transmit bit clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic receiver_reference_clock_i, // Receive sampling clock.
  input wire logic sync_request_a_i, // Sync request pin A.
  input wire logic sync_request_b_i, // Sync request pin B.
  input wire logic [9:0] parallel_input_word_i, // Word to send.
  input wire logic input_edge_select_i, // 1 rising, 0 falling edge.
  input wire logic serial_rx_i, // Serial stream in.
  output wire logic serial_tx_o, // Serial stream out.
  output wire logic serial_tx_oe_n_o, // Low while serial out drives.
  output wire logic [9:0] parallel_output_word_o, // Received word.
  output wire logic parallel_output_oe_n_o, // Low while word drives.
  output wire logic recovered_clock_o, // Recovered word clock.
  output wire logic lock_n_o, // Low while locked.
  output wire logic lock_oe_n_o // Low while lock pin drives.
);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side.
  ssl_tx_if tx_bus ();
  logic [1:0] req_meta_r;
  logic [1:0] req_r;

  always_ff @(posedge clk_i)
  begin
    req_meta_r <= {sync_request_b_i, sync_request_a_i};
    req_r <= req_meta_r;
  end

  // A lock indicator wired to one request input needs no other help.
  assign tx_bus.sync_req = |req_r;
  assign tx_bus.word = parallel_input_word_i;
  assign tx_bus.edge_sel = input_edge_select_i;
  assign serial_tx_o = tx_bus.txd;
  assign serial_tx_oe_n_o = tx_bus.txd_oe_n;

  ssl_tx ssl_tx_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tx(tx_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive side synchronisers.
  logic rst_meta_r;
  logic rrst_r;
  logic rxd_meta_r;
  logic rxd_r;
  logic rxd_d_r;

  always_ff @(posedge receiver_reference_clock_i)
  begin
    rst_meta_r <= rst_i;
    rrst_r <= rst_meta_r;
    rxd_meta_r <= serial_rx_i;
    rxd_r <= rxd_meta_r;
    rxd_d_r <= rxd_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary search.
  ssl_rx_st_t st_r, st_nxt;
  logic [3:0] pos_r;
  logic [3:0] lock_pos_r;
  logic [2:0] miss_r;
  logic [7:0] init_r;
  logic [1:0] rmt_r;
  logic [11:0] sh_r;
  logic [11:0] pframe_r;
  logic [11:0] rose_r;
  logic [3:0] hist_r [FRAME_BITS];
  logic [11:0] full;
  logic [3:0] full_pos;
  logic [1:0] rmt_nxt;
  logic [3:0] rel;

  wire rise = rxd_r & ~rxd_d_r;
  wire edge_seen = rxd_r ^ rxd_d_r;
  wire frame_end = pos_r == LAST_BIT;
  wire [11:0] sh_nxt = {sh_r[10:0], rxd_r};
  wire [11:0] pos_bit = 12'h001 << pos_r;
  wire [11:0] rose_all = rose_r | (rise ? pos_bit : 12'h000);
  wire multi = |(rose_all & (rose_all - 12'h001));
  wire rmt_same = multi && sh_nxt == pframe_r;
  wire rmt_block = rmt_nxt == RMT_FRAMES;
  wire uniq = full != 12'h000 && (full & (full - 12'h001)) == 12'h000;
  wire bnd_seen = rose_all[lock_pos_r];
  wire lock_gain = st_r == RX_HUNT && st_nxt == RX_LOCK;
  wire lock_loss = st_r == RX_LOCK && st_nxt == RX_HUNT;
  wire locked_nxt = st_nxt == RX_LOCK;

  assign rmt_nxt = !rmt_same ? 2'h0 :
    (rmt_r == RMT_FRAMES) ? rmt_r : rmt_r + 2'h1;
  // Bit position within the locked frame, counted modulo the frame length.
  assign rel = (pos_r >= lock_pos_r) ? pos_r - lock_pos_r :
    4'(pos_r + FRAME_LEN - lock_pos_r);

  // Positions that saw a rising edge in each of the last four frames.
  always_comb
  begin
    full = 12'h000;
    full_pos = 4'h0;
    for (int i = 0; i < FRAME_BITS; i++)
    begin
      full[i] = &{hist_r[i][2:0], rose_all[i]};
      if (full[i])
        full_pos = 4'(i);
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      RX_INIT:
        if (init_r == RX_PLL_CYC && edge_seen)
          st_nxt = RX_HUNT;
      RX_HUNT:
        if (frame_end && uniq && !rmt_block)
          st_nxt = RX_LOCK;
      RX_LOCK:
        if (frame_end && !bnd_seen && miss_r == BND_FRAMES - 3'h1)
          st_nxt = RX_HUNT;
      default:
        st_nxt = RX_INIT;
    endcase
  end

  always_ff @(posedge receiver_reference_clock_i)
  begin
    if (rrst_r)
    begin
      st_r <= RX_INIT;
      pos_r <= 4'h0;
      init_r <= 8'h00;
      lock_pos_r <= 4'h0;
      miss_r <= 3'h0;
      rmt_r <= 2'h0;
      sh_r <= 12'h000;
      pframe_r <= 12'h000;
      rose_r <= 12'h000;
    end
    else
    begin
      st_r <= st_nxt;
      pos_r <= frame_end ? 4'h0 : pos_r + 4'h1;
      // The reference clock must run for the PLL wait to end.
      if (init_r != RX_PLL_CYC)
        init_r <= init_r + 8'h01;
      sh_r <= sh_nxt;
      rose_r <= frame_end ? 12'h000 : rose_all;
      if (frame_end)
      begin
        pframe_r <= sh_nxt;
        rmt_r <= rmt_nxt;
      end
      if (lock_gain)
        lock_pos_r <= full_pos;
      // Once locked only the boundary position is watched.
      if (!locked_nxt)
        miss_r <= 3'h0;
      else if (frame_end && st_r == RX_LOCK)
        miss_r <= bnd_seen ? 3'h0 : miss_r + 3'h1;
    end
  end

  // Random data locks too, as soon as a single position stays unique.
  always_ff @(posedge receiver_reference_clock_i)
  begin
    for (int i = 0; i < FRAME_BITS; i++)
    begin
      if (rrst_r || st_r == RX_INIT || lock_loss)
        hist_r[i] <= 4'h0;
      else if (st_r == RX_HUNT && frame_end)
        hist_r[i] <= {hist_r[i][2:0], rose_all[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive outputs.
  logic lock_n_r;
  logic lock_oe_n_r;
  logic rout_oe_n_r;
  logic [9:0] rout_r;
  logic rclk_r;

  wire word_done = st_r == RX_LOCK && rel == LAST_BIT;
  // The clock only rises together with a fresh word, never mid-frame.
  wire rclk_hi = word_done || (rclk_r && rel < HALF_BIT - 4'h1);

  always_ff @(posedge receiver_reference_clock_i)
  begin
    if (rrst_r)
    begin
      lock_n_r <= 1'b1;
      lock_oe_n_r <= 1'b1;
      rout_oe_n_r <= 1'b1;
      rout_r <= 10'h000;
      rclk_r <= 1'b0;
    end
    else
    begin
      lock_n_r <= !locked_nxt;
      lock_oe_n_r <= 1'b0;
      rout_oe_n_r <= !locked_nxt;
      rclk_r <= st_r == RX_LOCK && locked_nxt && rclk_hi;
      if (word_done)
        rout_r <= sh_nxt[10:1];
    end
  end

  assign lock_n_o = lock_n_r;
  assign lock_oe_n_o = lock_oe_n_r;
  assign parallel_output_oe_n_o = rout_oe_n_r;
  assign parallel_output_word_o = rout_r;
  assign recovered_clock_o = rclk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic all_clear;
  always_comb
  begin
    all_clear = 1'b1;
    for (int i = 0; i < FRAME_BITS; i++)
      if (hist_r[i] != 4'h0)
        all_clear = 1'b0;
  end

  a_lock_four_frames: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    $fell(lock_n_r) |-> hist_r[lock_pos_r] == 4'hF && $past(frame_end))
    else $error("lock without four frames at one boundary");
  a_lock_not_rmt: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    st_r == RX_HUNT && frame_end && rmt_block |=> lock_n_r)
    else $error("lock declared on a false lock pattern");
  a_lock_drop_four: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    st_r == RX_LOCK && frame_end && !bnd_seen && miss_r == 3'h3
    |=> lock_n_r && rout_oe_n_r)
    else $error("lock not dropped after four missed boundaries");
  a_lock_keep_bnd: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    st_r == RX_LOCK && frame_end && bnd_seen |=> !lock_n_r)
    else $error("lock lost while boundary still present");
  a_hunt_restart: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    $rose(lock_n_r) |=> all_clear && st_r == RX_HUNT)
    else $error("search not restarted after loss of lock");
  a_out_tristate: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    lock_n_r |-> rout_oe_n_r && !rclk_r)
    else $error("word outputs active while unlocked");
  a_init_needs_edge: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    st_r == RX_INIT && !edge_seen |=> st_r == RX_INIT)
    else $error("acquisition started without a serial edge");
  a_word_strobe: assert property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    word_done && locked_nxt |=> rout_r == $past(sh_nxt[10:1]) && !rout_oe_n_r)
    else $error("received word not presented while locked");

  c_lock_gain: cover property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r) lock_gain);
  c_lock_loss: cover property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r) lock_loss);
  c_rmt_block: cover property (
    @(posedge receiver_reference_clock_i) disable iff (rrst_r)
    st_r == RX_HUNT && frame_end && uniq && rmt_block);

endmodule : ssl_top
`default_nettype wire

/* File: testbench/ssl_link_partner.sv */
// Far-side serializer model that drives the receive serial line.
// Assumes one line bit per rising edge of the reference clock.
`timescale 1ns/10ps
`default_nettype none
module ssl_link_partner (
  input wire logic clk_i, // Line bit clock.
  input wire logic [1:0] mode_i, // 0 quiet, 1 sync, 2 random, 3 repeat.
  output logic line_o, // Serial line.
  output logic [9:0] sent_word_o, // Word of the frame now ending.
  output logic sent_stb_o // High while the stop bit is on the line.
);
  logic [11:0] frame_r = 12'hFFF;
  logic [3:0] bit_r = 4'h0;
  logic [9:0] word_r = 10'h3FF;

  function automatic logic [9:0] pick(input logic [1:0] m);
    case (m)
      2'h1: return 10'h3E0;
      2'h2: return 10'($urandom);
      2'h3: return 10'h155;
      default: return 10'h3FF;
    endcase
  endfunction : pick

  initial
  begin
    line_o = 1'b1;
    sent_word_o = 10'h3FF;
    sent_stb_o = 1'b0;
  end

  // Quiet mode holds the line high, so no edge reaches the receiver.
  always @(posedge clk_i)
  begin
    if (bit_r == 4'h0)
    begin
      word_r = pick(mode_i);
      frame_r = (mode_i == 2'h0) ? 12'hFFF : {1'b1, word_r, 1'b0};
    end
    line_o <= frame_r[4'hB - bit_r];
    sent_stb_o <= (bit_r == 4'hB);
    sent_word_o <= word_r;
    bit_r = (bit_r == 4'hB) ? 4'h0 : bit_r + 4'h1;
  end
endmodule : ssl_link_partner
`default_nettype wire

/* File: testbench/serdes_link_sync_lock_test.sv */
// Self-checking bench for the link sync and lock top.
// Assumes the far-side model drives the receive line on the receiver reference clock.
`timescale 1ns/10ps
`default_nettype none
module serdes_link_sync_lock_test;
  logic clk_i = 1'b0;
  logic rx_clk = 1'b0;
  logic rst_i = 1'b1;
  logic sync_a = 1'b0;
  logic sync_b = 1'b0;
  logic [9:0] word = 10'h000;
  logic edge_sel = 1'b1;
  logic [1:0] rx_mode = 2'h0;
  logic serial_rx, tx, tx_oe_n, rword_oe_n, rclk, rclk_d, lock_n, lock_oe_n;
  logic [9:0] rword, sent_word;
  logic sent_stb;
  logic [11:0] sh = 12'h000;
  logic [15:0] tx_q[$];
  logic [9:0] rx_q[$];
  bit aligned = 1'b0;
  int ph = 0, run = 0, sync_cnt = 0, post = 0, took = 0;
  int n_errors = 0;
  int samples_checked = 0;

  ssl_top ssl_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .receiver_reference_clock_i(rx_clk), .sync_request_a_i(sync_a),
    .sync_request_b_i(sync_b), .parallel_input_word_i(word),
    .input_edge_select_i(edge_sel), .serial_rx_i(serial_rx),
    .serial_tx_o(tx), .serial_tx_oe_n_o(tx_oe_n),
    .parallel_output_word_o(rword), .parallel_output_oe_n_o(rword_oe_n),
    .recovered_clock_o(rclk), .lock_n_o(lock_n), .lock_oe_n_o(lock_oe_n));
  ssl_link_partner ssl_link_partner_inst (.clk_i(rx_clk), .mode_i(rx_mode),
    .line_o(serial_rx), .sent_word_o(sent_word), .sent_stb_o(sent_stb));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #3;
    forever #6 rx_clk = ~rx_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic cmp_val(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic exp, input logic got);
    cmp_val({15'h0000, exp}, {15'h0000, got});
  endtask : cmp_bit

  task automatic wait_lock(input logic want, input int n, output int t);
    t = 0;
    while (lock_n !== want && t <= n)
    begin
      @(posedge rx_clk);
      t++;
    end
  endtask : wait_lock

  ////////////////////////////////////////////////////////////////////////////
  // The first data word has short runs of ones so that only a sync frame
  // can align the frame grid; the second is applied in mid-burst.
  task automatic burst(input bit use_b, input logic sel);
    logic [9:0] w1;
    logic [9:0] w2;
    w1 = 10'($urandom) & 10'h2DB;
    w2 = 10'($urandom);
    if (w2 == 10'h3E0)
      w2 = 10'h3E1;
    word <= w1;
    edge_sel <= sel;
    repeat (36) @(posedge clk_i);
    tx_q.push_back(16'h0402);
    tx_q.push_back({4'h0, 1'b1, w1, 1'b0});
    tx_q.push_back({4'h0, 1'b1, w2, 1'b0});
    if (use_b)
      sync_b <= 1'b1;
    else
      sync_a <= 1'b1;
    repeat (120) @(posedge clk_i);
    sync_a <= 1'b0;
    sync_b <= 1'b0;
    repeat (200) @(posedge clk_i);
    word <= w2;
    for (int i = 0; i < 13000 && tx_q.size() > 0; i++)
      @(posedge clk_i);
    cmp_val(16'h0000, 16'(tx_q.size()));
  endtask : burst

  task automatic tx_seq();
    burst(1'b0, 1'b1);
    burst(1'b1, 1'b0);
    sync_a <= 1'b1;
    repeat (48) @(posedge clk_i);
    sync_a <= 1'b0;
    repeat (400) @(posedge clk_i);
    cmp_val(16'h0000, 16'(sync_cnt));
  endtask : tx_seq

  task automatic rx_seq();
    int t;
    wait_lock(1'b0, 240, t);
    cmp_bit(1'b1, t > 240);
    rx_mode <= 2'h3;
    wait_lock(1'b0, 360, t);
    cmp_bit(1'b1, t > 360);
    rx_mode <= 2'h2;
    wait_lock(1'b0, 6000, t);
    cmp_bit(1'b1, t <= 6000);
    rx_mode <= 2'h3;
    wait_lock(1'b1, 360, t);
    cmp_bit(1'b1, t > 360);
    rx_mode <= 2'h0;
    wait_lock(1'b1, 108, t);
    cmp_bit(1'b1, t > 36 && t <= 108);
    rx_mode <= 2'h1;
    wait_lock(1'b0, 120, t);
    cmp_bit(1'b1, t > 36 && t <= 120);
    rx_mode <= 2'h2;
  endtask : rx_seq

  ////////////////////////////////////////////////////////////////////////////
  // Frames are cut on the grid fixed by the first run of six ones.
  always @(posedge clk_i)
  begin
    if (!rst_i && tx_oe_n === 1'b0)
    begin
      sh = {sh[10:0], tx};
      if (tx === 1'b1)
        run++;
      else
      begin
        if (run == 6 && !aligned)
        begin
          aligned = 1'b1;
          ph = 6;
        end
        run = 0;
      end
      if (aligned && ph == 11)
      begin
        if (sh === 12'hFC0)
          sync_cnt++;
        else
        begin
          if (sync_cnt > 0)
          begin
            cmp_val(tx_q.pop_front(), 16'(sync_cnt));
            sync_cnt = 0;
            post = 2;
          end
          if (post > 0)
          begin
            cmp_val(tx_q.pop_front(), {4'h0, sh});
            post--;
          end
        end
      end
      ph = (ph == 11) ? 0 : ph + 1;
    end
  end

  always @(posedge rx_clk)
  begin
    if (sent_stb === 1'b1)
      rx_q.push_back(sent_word);
    if (lock_oe_n === 1'b0 && lock_n === 1'b1)
      cmp_val(16'h0002, {14'h0000, rword_oe_n, rclk});
    if (lock_n === 1'b0 && rclk === 1'b1 && rclk_d === 1'b0)
    begin
      while (rx_q.size() > 1)
        void'(rx_q.pop_front());
      cmp_val({6'h00, rx_q.pop_front()}, {5'h00, rword_oe_n, rword});
    end
    rclk_d = rclk;
  end

  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(23269));
    repeat (6) @(posedge clk_i);
    cmp_val(16'h0007, {13'h0000, tx_oe_n, lock_oe_n, rword_oe_n});
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    while (tx_oe_n !== 1'b0 && took < 100)
    begin
      @(posedge clk_i);
      took++;
    end
    cmp_bit(1'b1, took >= 32 && took < 100);
    fork
      tx_seq();
      rx_seq();
    join
    complete_run();
  end
endmodule : serdes_link_sync_lock_test
`default_nettype wire
